// ===== rtl/irq_pkg.sv
// Shared constants and carrier types of the two-level vectored interrupt controller.
// Assumes a 32-bit classic Wishbone register bus and a core that reports instruction ends.
package irq_pkg;

    localparam int             NUM_SRC       = 17;
    localparam int             ORDER_W       = 5;
    localparam logic [16:0]    SRC_PRESENT   = 17'h1DFFF;
    localparam logic [16:0]    AUTO_CLEAR    = 17'h0000F;
    localparam int             PIN0_SRC      = 0;
    localparam int             PIN1_SRC      = 2;
    localparam int             BASE_SRCS     = 7;
    localparam int             EXT_SRCS      = 10;
    localparam int             GLOBAL_EN_BIT = 7;
    localparam logic [31:0]    PRIO_UNUSED   = 32'h00000080;

    localparam logic [15:0]    VEC_BASE      = 16'h0003;
    localparam logic [15:0]    VEC_STEP      = 16'h0008;

    localparam logic [7:0]     OFS_ENABLE    = 8'h00;
    localparam logic [7:0]     OFS_EXT_EN    = 8'h04;
    localparam logic [7:0]     OFS_PRIO      = 8'h08;
    localparam logic [7:0]     OFS_EXT_PRIO  = 8'h0C;
    localparam logic [7:0]     OFS_PENDING   = 8'h10;
    localparam logic [7:0]     OFS_STATUS    = 8'h14;

    localparam logic [7:0]     ENABLE_RESET  = 8'h00;
    localparam logic [9:0]     EXT_RESET     = 10'h000;
    localparam logic [6:0]     PRIO_RESET    = 7'h00;
    localparam logic [16:0]    PEND_RESET    = 17'h00000;

    localparam int             DETECT_CYCLES = 1;
    localparam int             CALL_CYCLES   = 4;
    localparam int             IRQ_RETURN_INSTR_CYCLES   = 5;
    localparam int             DIV_CYCLES    = 8;
    localparam int             FAST_CYCLES   = DETECT_CYCLES + CALL_CYCLES;
    localparam int             WORST_CYCLES  = DETECT_CYCLES + IRQ_RETURN_INSTR_CYCLES + DIV_CYCLES
                                               + CALL_CYCLES;
    localparam logic [2:0]     CALL_LAST     = 3'(CALL_CYCLES - 1);

    typedef enum logic [0:0] {ST_IDLE, ST_CALL} state_type;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic [15:0]        vector;
        logic [ORDER_W-1:0] order;
        logic               high;
    } call_type;

endpackage

// ===== rtl/sync_bits.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are slow enough that two stages settle them.
`timescale 1ns/1ps
module sync_bits #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                stage1[i]  <= 1'b0;
                syncOut[i] <= 1'b0;
            end else begin
                stage1[i]  <= asyncIn[i];
                syncOut[i] <= stage1[i];
            end
        end
    end
endmodule

// ===== rtl/prio_pick.sv
// Fixed-order arbiter: the lowest set index wins.
// Assumes a purely combinational use inside the controller.
`timescale 1ns/1ps
module prio_pick
    import irq_pkg::*;
(
    // Candidates
    input  wire logic [NUM_SRC-1:0] req,
    // Winner
    output logic                    found,
    output logic [ORDER_W-1:0]      index
);
    logic [NUM_SRC:0]   below;
    logic [NUM_SRC-1:0] first;

    assign below[0] = 1'b0;
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_chain
        assign first[i]   = req[i] & ~below[i];
        assign below[i+1] = below[i] | req[i];
    end
    assign found = below[NUM_SRC];

    always_comb begin
        index = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (first[i]) begin
                index = index | ORDER_W'(i);
            end
        end
    end
endmodule

// ===== rtl/two_level_vectored_interrupt_controller.sv
// Two-level vectored interrupt controller with a classic Wishbone register slave.
// Assumes the core pulses instrDone at each ordinary instruction end and retiDone
// instead of it when a return-from-interrupt completes.
`timescale 1ns/1ps
// Contract
// - A valid source event sets its pending flag regardless of enables.
// - Any of a source's several flags counts as its pending request.
// - Enabled pending source requests; call issued at the next instruction end.
// - Disabled sources are ignored; no call results from them.
// - Return resumes the interrupted program; the core restores the address.
// - Individual enables count only while global enable bit 7 is set.
// - Global enable low blocks every source.
// - Vectoring clears only pin and basic timer pending flags.
// - Flag still set after return re-enters after one more instruction.
// - Software-written pending ones act exactly like hardware-set flags.
// - High pre-empts low; nothing pre-empts a high routine.
// - All priority selects reset low.
// - Simultaneous requests: high level served before low level.
// - Equal level: smallest fixed order number, 0 to 16, wins.
// - Vector is 0x0003 plus eight bytes per order number.
// - Requests decoded every clock; fastest response five cycles.
// - Pending at return: one more instruction completes before the call.
// - Worst unnested response is eighteen cycles.
// - Equal or higher routine running holds the request until return plus one.
// - Global and individual enables reset to zero.
module two_level_vectored_interrupt_controller
    import irq_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // Register bus
    input  wire irq_pkg::wb_req_type  wbReq,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // Interrupt sources
    input  wire logic                 ext_pin_irq0,
    input  wire logic                 ext_pin_irq1,
    input  wire logic [16:0]          flagSetA,
    input  wire logic [16:0]          flagSetB,
    // Core side
    input  wire logic                 instrDone,
    input  wire logic                 retiDone,
    output logic                      callStart,
    output irq_pkg::call_type         callInfo,
    output logic [1:0]                inService
);
    import irq_pkg::*;

    logic [7:0]         enableReg;
    logic [9:0]         extEnableReg;
    logic [6:0]         prioReg;
    logic [9:0]         extPrioReg;
    logic [16:0]        pending;
    logic [1:0]         pinSync;
    logic [1:0]         pinLast;
    logic               skipOne;
    logic               detFound;
    call_type           detCall;
    state_type          state;
    logic [2:0]         callCount;
    logic [16:0]        setMaskQ;

    // Bus decode.
    wire                busReq   = wbReq.cyc & wbReq.stb & ~wb_ack_o;
    wire                busWr    = busReq & wbReq.we;
    wire [31:0]         laneMask = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}},
                                    {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
    wire                hitEn    = wbReq.adr == OFS_ENABLE;
    wire                hitExtEn = wbReq.adr == OFS_EXT_EN;
    wire                hitPrio  = wbReq.adr == OFS_PRIO;
    wire                hitExtPr = wbReq.adr == OFS_EXT_PRIO;
    wire                hitPend  = wbReq.adr == OFS_PENDING;
    wire                hitStat  = wbReq.adr == OFS_STATUS;
    wire [31:0]         wrMerge  = wbReq.dat & laneMask;

    // Per-source views of the split enable and priority registers.
    wire [16:0]         srcEnable = {extEnableReg, enableReg[BASE_SRCS-1:0]} & SRC_PRESENT;
    wire [16:0]         srcHigh   = {extPrioReg, prioReg} & SRC_PRESENT;
    wire                globalOn  = enableReg[GLOBAL_EN_BIT];

    // Sources that own several flags present each one separately.
    wire [1:0]          pinRise  = pinSync & ~pinLast;
    wire [16:0]         pinSet   = 17'(pinRise[0]) << PIN0_SRC | 17'(pinRise[1]) << PIN1_SRC;
    wire [16:0]         hwSet    = (flagSetA | flagSetB | pinSet) & SRC_PRESENT;
    wire                pendWr   = busWr & hitPend;
    wire [16:0]         swSet    = pendWr ? wrMerge[16:0] & SRC_PRESENT : 17'h00000;
    wire [16:0]         swClr    = pendWr ? ~wbReq.dat[16:0] & laneMask[16:0] : 17'h00000;

    // Request resolution, evaluated on every clock.
    wire [16:0]         active   = pending & srcEnable & {17{globalOn}};
    wire [16:0]         highReq  = active & srcHigh;
    wire [16:0]         lowReq   = active & ~srcHigh;
    wire                highOk   = ~inService[1];
    wire                lowOk    = inService == 2'b00;
    wire                useHigh  = highOk & (|highReq);
    wire [16:0]         cand     = useHigh ? highReq : (lowOk ? lowReq : 17'h00000);
    wire                pickFound;
    wire [ORDER_W-1:0]  pickIndex;
    wire [15:0]         pickVec  = VEC_BASE + VEC_STEP * 16'(pickIndex);

    // The call is only issued at an instruction end, and never at the first end after a
    // return, so the interrupted program always makes progress between two routines.
    wire                take     = (state == ST_IDLE) & instrDone & detFound & ~skipOne;
    wire [16:0]         takeMask = 17'(1) << detCall.order;
    wire [16:0]         autoClr  = take ? takeMask & AUTO_CLEAR : 17'h00000;
    wire [16:0]         setMask  = hwSet | swSet;
    wire [16:0]         next_pending = (pending & ~(swClr | autoClr)) | setMask;

    wire [1:0]          retClear = inService[1] ? 2'b10 : inService & 2'b01;
    wire [1:0]          takeSet  = take ? (detCall.high ? 2'b10 : 2'b01) : 2'b00;
    wire [1:0]          next_inService = (inService & ~(retiDone ? retClear : 2'b00)) | takeSet;

    wire [31:0]         readMux  =
        hitEn    ? 32'(enableReg) :
        hitExtEn ? 32'({extEnableReg[9:7], 1'b0, extEnableReg[5:0]}) :
        hitPrio  ? (32'(prioReg) | PRIO_UNUSED) :
        hitExtPr ? 32'({extPrioReg[9:7], 1'b0, extPrioReg[5:0]}) :
        hitPend  ? 32'(pending) :
        hitStat  ? 32'({skipOne, state, inService, 3'h0, callInfo.order}) :
                   32'h00000000;

    sync_bits #(
        .W       (2)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .asyncIn ({ext_pin_irq1, ext_pin_irq0}),
        .syncOut (pinSync)
    );

    prio_pick u_pick (
        .req     (cand),
        .found   (pickFound),
        .index   (pickIndex)
    );

    // Register bus slave: single-cycle answer, unmapped reads return zero.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? readMux : 32'h00000000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            enableReg    <= ENABLE_RESET;
            extEnableReg <= EXT_RESET;
            prioReg      <= PRIO_RESET;
            extPrioReg   <= EXT_RESET;
        end else begin
            if (busWr & hitEn & wbReq.sel[0]) begin
                enableReg <= wbReq.dat[7:0];
            end
            if (busWr & hitExtEn) begin
                extEnableReg <= (extEnableReg & ~laneMask[9:0]) | wrMerge[9:0];
            end
            if (busWr & hitPrio & wbReq.sel[0]) begin
                prioReg <= wbReq.dat[6:0];
            end
            if (busWr & hitExtPr) begin
                extPrioReg <= (extPrioReg & ~laneMask[9:0]) | wrMerge[9:0];
            end
        end
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pending  <= PEND_RESET;
            pinLast  <= 2'b00;
            setMaskQ <= 17'h00000;
        end else begin
            pending  <= next_pending;
            pinLast  <= pinSync;
            setMaskQ <= setMask;
        end
    end

    // One cycle of detection; a flag cleared in the detect cycle can still be called
    // once, which service software must tolerate.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            detFound <= 1'b0;
            detCall  <= '0;
        end else begin
            detFound        <= pickFound;
            detCall.order   <= pickIndex;
            detCall.vector  <= pickVec;
            detCall.high    <= useHigh;
        end
    end

    // A return marks the next instruction end as one that must run before any call.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            skipOne <= 1'b0;
        end else if (retiDone) begin
            skipOne <= 1'b1;
        end else if (instrDone) begin
            skipOne <= 1'b0;
        end
    end

    // The call occupies the core for the long call length; the return address itself
    // is saved and restored by the core.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            callCount <= 3'h0;
            callStart <= 1'b0;
            callInfo  <= '0;
            inService <= 2'b00;
        end else begin
            callStart <= take;
            inService <= next_inService;
            if (take) begin
                callInfo <= detCall;
            end
            case (state)
                ST_IDLE: begin
                    callCount <= 3'h0;
                    if (take) begin
                        state <= ST_CALL;
                    end
                end
                ST_CALL: begin
                    callCount <= callCount + 3'h1;
                    if (callCount == CALL_LAST) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    a_call_boundary: assert property (@(posedge ref_clk) disable iff (!rst_n)
        callStart |-> $past(instrDone) && $past(detFound))
        else $error("Call issued outside an instruction end.");

    a_global_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !globalOn && !$past(globalOn) |=> !callStart)
        else $error("Call issued with global enable low.");

    a_high_nopreempt: assert property (@(posedge ref_clk) disable iff (!rst_n)
        callStart |-> !$past(inService[1]))
        else $error("High routine was pre-empted.");

    a_low_needs_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        callStart && !callInfo.high |-> $past(inService) == 2'b00)
        else $error("Low call while a routine was in service.");

    a_vector_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
        callStart |-> callInfo.vector == VEC_BASE + VEC_STEP * 16'(callInfo.order))
        else $error("Vector does not match order number.");

    a_auto_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        callStart && AUTO_CLEAR[callInfo.order] |->
            pending[callInfo.order] == setMaskQ[callInfo.order])
        else $error("Auto-cleared flag still pending after the call.");

    a_skip_after_ret: assert property (@(posedge ref_clk) disable iff (!rst_n)
        retiDone ##1 instrDone |=> !callStart)
        else $error("Call made without one instruction after return.");

    a_call_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
        callStart |=> (!callStart) [*4])
        else $error("Calls closer than the long call length.");

    a_marker_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        callStart |-> inService[callInfo.high])
        else $error("In-service marker not set by the call.");

    a_sw_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pendWr && wbReq.sel[0] && wbReq.dat[0] |=> pending[0])
        else $error("Software-set flag not pending.");

endmodule

// ===== sim/core_model.sv
// Behavioural core: ends one instruction per clock while run is high and no call is running.
// Assumes the controller's callStart pulse and a return request from the bench.
`timescale 1ns/1ps
module core_model
    import irq_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Control
    input  wire logic run,
    input  wire logic retiReq,
    input  wire logic callStart,
    // Instruction ends
    output logic      instrDone,
    output logic      retiDone
);
    logic [2:0] busy;
    logic       retPend;

    // The call cycles end no instruction, so a request cannot be taken twice.
    always_ff @(posedge ref_clk) begin
        instrDone <= 1'b0;
        retiDone  <= 1'b0;
        if (!rst_n) begin
            busy    <= 3'h0;
            retPend <= 1'b0;
        end else begin
            if (retiReq) retPend <= 1'b1;
            if (callStart) begin
                busy <= CALL_LAST + 3'h1;
            end else if (busy != 3'h0) begin
                busy <= busy - 3'h1;
            end else if (run && (retPend || retiReq)) begin
                retiDone <= 1'b1;
                retPend  <= 1'b0;
            end else if (run) begin
                instrDone <= 1'b1;
            end
        end
    end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the two-level vectored interrupt controller.
// Assumes core_model ends one instruction per clock outside calls.
`timescale 1ns/1ps
module testbench;
    import irq_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    wb_req_type  wbReq = '0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        ext_pin_irq0 = 1'b0;
    logic        ext_pin_irq1 = 1'b0;
    logic [16:0] flagSetA = 17'h00000;
    logic [16:0] flagSetB = 17'h00000;
    logic        run = 1'b0;
    logic        retiReq = 1'b0;
    logic        instrDone;
    logic        retiDone;
    logic        callStart;
    call_type    callInfo;
    logic [1:0]  inService;
    logic [31:0] rd;
    int          cnt;
    int          err_count = 0;
    int          n_tests = 0;

    always #2.5 ref_clk = ~ref_clk;

    two_level_vectored_interrupt_controller i_dut (.ref_clk, .rst_n, .wbReq, .wb_dat_o,
        .wb_ack_o, .ext_pin_irq0, .ext_pin_irq1, .flagSetA, .flagSetB, .instrDone,
        .retiDone, .callStart, .callInfo, .inService);
    core_model i_core (.ref_clk, .rst_n, .run, .retiReq, .callStart, .instrDone,
        .retiDone);

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic timeout(string what);
        err_count++;
        $display("ERROR %s expected answer seen none", what);
        wrap_up();
    endtask

    task automatic bus(logic we, logic [7:0] adr, logic [31:0] dat);
        int k;
        wbReq <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (wb_ack_o === 1'b1) break;
        end
        if (k == 20) timeout("bus ack");
        rd = wb_dat_o;
        wbReq <= '0;
        @(posedge ref_clk);
    endtask

    task automatic wait_call(int lim);
        for (cnt = 1; cnt <= lim; cnt++) begin
            @(posedge ref_clk);
            if (callStart === 1'b1) return;
        end
        cnt = 0;
    endtask

    task automatic expect_call(int ord, logic hi);
        wait_call(20);
        if (cnt == 0) timeout("call");
        check("order", 32'(ord), 32'(callInfo.order));
        check("vector", 32'(VEC_BASE + VEC_STEP * ord), 32'(callInfo.vector));
        check("level", 32'(hi), 32'(callInfo.high));
    endtask

    task automatic pulse(logic [16:0] a, logic [16:0] b);
        flagSetA <= a;
        flagSetB <= b;
        @(posedge ref_clk);
        flagSetA <= 17'h00000;
        flagSetB <= 17'h00000;
    endtask

    task automatic irq_return_instr();
        int k;
        retiReq <= 1'b1;
        @(posedge ref_clk);
        retiReq <= 1'b0;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (retiDone === 1'b1) return;
        end
        timeout("return");
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        run   <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        run   <= 1'b1;
        @(posedge ref_clk);
    endtask

    task automatic t_reset();
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        bus(1'b0, OFS_ENABLE, '0);
        check("enable", 32'h0, rd);
        bus(1'b0, OFS_EXT_EN, '0);
        check("ext enable", 32'h0, rd);
        bus(1'b0, OFS_PRIO, '0);
        check("priority", 32'h80, rd);
        bus(1'b0, OFS_EXT_PRIO, '0);
        check("ext priority", 32'h0, rd);
        // A software-set flag must stay pending while every source is masked.
        bus(1'b1, OFS_PENDING, 32'h1);
        bus(1'b0, OFS_PENDING, '0);
        check("sw pending", 32'h1, rd);
        bus(1'b1, OFS_PENDING, 32'h0);
        check("in service", 32'h0, 32'(inService));
        $display("reset test done");
    endtask

    task automatic t_mask();
        pulse(17'h00010, 17'h00000);
        bus(1'b0, OFS_PENDING, '0);
        check("pending", 32'h10, rd);
        wait_call(20);
        check("disabled call", 32'h0, 32'(cnt));
        bus(1'b1, OFS_ENABLE, 32'h10);
        wait_call(20);
        check("global off call", 32'h0, 32'(cnt));
        bus(1'b1, OFS_ENABLE, 32'h90);
        expect_call(4, 1'b0);
        bus(1'b0, OFS_PENDING, '0);
        check("pending kept", 32'h10, rd);
        check("in service", 32'h1, 32'(inService));
        irq_return_instr();
        wait_call(10);
        // The instruction after the return ends first; the call comes at the next end.
        check("reentry", 32'h3, 32'(cnt));
        bus(1'b1, OFS_PENDING, 32'h0);
        irq_return_instr();
        wait_call(20);
        check("no reentry", 32'h0, 32'(cnt));
        check("in service", 32'h0, 32'(inService));
        bus(1'b0, OFS_STATUS, '0);
        check("status", 32'h4, rd);
        $display("masking test done");
    endtask

    task automatic t_arb();
        do_reset();
        bus(1'b1, OFS_ENABLE, 32'hFF);
        bus(1'b1, OFS_EXT_EN, 32'h3FF);
        bus(1'b1, OFS_PENDING, 32'h1048);
        expect_call(3, 1'b0);
        bus(1'b0, OFS_PENDING, '0);
        check("auto clear", 32'h1040, rd);
        bus(1'b1, OFS_EXT_PRIO, 32'h20);
        expect_call(12, 1'b1);
        check("in service", 32'h3, 32'(inService));
        bus(1'b1, OFS_PRIO, 32'h40);
        wait_call(20);
        check("high nested", 32'h0, 32'(cnt));
        bus(1'b1, OFS_PENDING, 32'h40);
        irq_return_instr();
        // The marker clears at the edge that samples the return, so look one edge later.
        @(posedge ref_clk);
        check("in service", 32'h1, 32'(inService));
        expect_call(6, 1'b1);
        $display("arbitration test done");
    endtask

    task automatic t_vec();
        logic [16:0] b;
        do_reset();
        for (int o = 0; o < NUM_SRC; o++) begin
            if (o == 13) continue;
            b = 17'(1) << o;
            bus(1'b1, OFS_ENABLE, 32'h80 | 32'(b[6:0]));
            bus(1'b1, OFS_EXT_EN, 32'(b[16:7]));
            // Odd sources use the second set input to cover the OR of flags.
            pulse(o % 2 ? 17'h0 : b, o % 2 ? b : 17'h0);
            expect_call(o, 1'b0);
            check("latency", 32'h1, 32'(cnt <= FAST_CYCLES));
            bus(1'b1, OFS_PENDING, 32'h0);
            irq_return_instr();
        end
        $display("vector test done");
    endtask

    task automatic t_pins();
        do_reset();
        ext_pin_irq1 <= 1'b1;
        repeat (6) @(posedge ref_clk);
        bus(1'b0, OFS_PENDING, '0);
        check("pin pending", 32'h4, rd);
        pulse(17'h0, 17'h20);
        bus(1'b0, OFS_PENDING, '0);
        check("flag pending", 32'h24, rd);
        bus(1'b1, OFS_ENABLE, 32'h81);
        ext_pin_irq0 <= 1'b1;
        expect_call(0, 1'b0);
        bus(1'b0, OFS_PENDING, '0);
        check("pin auto clear", 32'h24, rd);
        ext_pin_irq0 <= 1'b0;
        ext_pin_irq1 <= 1'b0;
        $display("pin test done");
    endtask

    initial begin
        do_reset();
        t_reset();
        t_mask();
        t_arb();
        t_vec();
        t_pins();
        wrap_up();
    end
endmodule
